// ==== design/qsp_sram_port.sv ====
// pin-level port logic of a separate-io four-word burst sram
`timescale 1ns/10ps
`default_nettype none

// How it works
// R1: write select low at a positive clock rise starts a write; high ignores data.
// R2: only byte lanes with their select low are stored; others keep old bytes.
// R3: select 0 covers data bits 8..0, select 1 covers bits 17..9.
// R4: controller presents lane selects with the data word they qualify.
// R5: address sampled at positive rise only when the port is selected.
// R6: 21-bit address picks a four-word burst location; the code uses only bits 3..0 (16 locations).
// R7: read words launch on both clock rises; outputs float when deselected.
// R8: read select low starts a read; when deselected, burst ends then outputs float.
// R9: every read returns four consecutive words of the location.
// R10: valid flag is high with read data and moves with echo clock edges.
// R11: accesses start only on a positive clock rise.
// R12: negative clock rise captures second-half inputs and launches read words.
// R13: echo clock pair runs freely, following the input clock.
// R14: termination range caught once after power-up; low picks low range. The code catches it again after every reset release.
// R15: write data sampled on both rises only during an active write.
// R16: pll mode returns first read word two and a half cycles after request.
// R17: pll disabled gives legacy mode with one cycle read latency.
// R18: each access moves four words over two input clock cycles.
// R19: reads and writes may overlap; their addresses use alternating positive rises.
module qsp_sram_port (
  input  wire logic                        CLK_I,
  input  wire logic                        RST_N_I,
  input  wire logic                        K_I,
  input  wire logic                        K_N_I,
  input  wire logic                        WRITE_PORT_SELECT_N_I,
  input  wire logic                        READ_PORT_SELECT_N_I,
  input  wire logic [qsp_pkg::LANES-1:0]   BYTE_LANE_WRITE_SELECT_N_I,
  input  wire logic [qsp_pkg::ADDR_W-1:0]  ADDR_I,
  input  wire logic [qsp_pkg::DATA_W-1:0]  D_I,
  input  wire logic                        TERMINATION_RANGE_SELECT_I,
  input  wire logic                        PLL_DISABLE_N_I,
  output logic      [qsp_pkg::DATA_W-1:0]  Q_O,
  output logic                             Q_OE_O,
  output logic                             OUTPUT_VALID_FLAG_O,
  output logic                             ECHO_TIMING_OUT_O,
  output logic                             ECHO_TIMING_OUT_N_O,
  output logic                             TERM_RANGE_HIGH_O
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [qsp_pkg::SYNC_W-1:0]  pin_raw;
  logic [qsp_pkg::SYNC_W-1:0]  pin_s;
  logic                        k_s;
  logic                        kn_s;
  logic                        wps_n_s;
  logic                        rps_n_s;
  logic [qsp_pkg::LANES-1:0]   bws_n_s;
  logic [qsp_pkg::ADDR_W-1:0]  addr_s;
  logic [qsp_pkg::DATA_W-1:0]  d_s;
  logic                        odt_s;
  logic                        pll_dis_n_s;

  // every pin takes the same two flops, so data stays aligned to the clocks
  assign pin_raw = {K_I, K_N_I, WRITE_PORT_SELECT_N_I, READ_PORT_SELECT_N_I,
                    BYTE_LANE_WRITE_SELECT_N_I, ADDR_I, D_I,
                    TERMINATION_RANGE_SELECT_I, PLL_DISABLE_N_I};
  assign {k_s, kn_s, wps_n_s, rps_n_s, bws_n_s, addr_s, d_s, odt_s, pll_dis_n_s} = pin_s;

  qsp_sync #(
    .W       (qsp_pkg::SYNC_W)
  ) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (pin_raw),
    .q_o     (pin_s)
  );

  // ----------------------------------------------------------------
  // input clock edges and echo clocks
  // ----------------------------------------------------------------
  logic cq_q;
  logic cqn_q;
  logic k_rise;
  logic kn_rise;
  logic beat_edge;

  // echo pair is the delayed clock level, so it also serves as edge history
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cq_q  <= 1'h0;
      cqn_q <= 1'h0;
    end else begin
      cq_q  <= k_s;  // R13
      cqn_q <= kn_s; // R13
    end
  end

  assign k_rise    = k_s & ~cq_q;
  assign kn_rise   = kn_s & ~cqn_q;
  assign beat_edge = k_rise | kn_rise;  // R12

  // ----------------------------------------------------------------
  // write port
  // ----------------------------------------------------------------
  qsp_mem_if mb ();

  logic                        wr_act_q;
  logic [qsp_pkg::BEAT_W-1:0]  wr_beat_q;
  logic [qsp_pkg::MEM_AW-1:0]  wr_addr_q;
  logic                        wr_start;
  logic                        wr_en;
  logic [qsp_pkg::LANES-1:0]   wr_lane;

  // a positive rise mid-burst belongs to beat 2, so a new write waits
  assign wr_start = k_rise & ~wr_act_q & ~wps_n_s;  // R1 R11 R19

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_act_q  <= 1'h0;
      wr_beat_q <= '0;
      wr_addr_q <= '0;
    end else if (wr_start) begin
      wr_act_q  <= 1'h1;
      wr_beat_q <= 2'h1;
      wr_addr_q <= addr_s[qsp_pkg::MEM_AW-1:0];  // R5 R6
    end else if (beat_edge && wr_act_q) begin
      wr_beat_q <= wr_beat_q + 2'h1;
      if (wr_beat_q == qsp_pkg::LAST_BEAT) begin
        wr_act_q <= 1'h0;  // R18
      end
    end
  end

  // data and lane selects are taken on the same edge as each word
  assign wr_en   = wr_start | (beat_edge & wr_act_q);  // R15
  assign wr_lane = ~bws_n_s & {qsp_pkg::LANES{wr_en}};  // R2 R3 R4

  assign mb.wr_en   = wr_en;
  assign mb.wr_lane = wr_lane;
  assign mb.wr_data = d_s;
  assign mb.wr_addr = wr_start ? addr_s[qsp_pkg::MEM_AW-1:0] : wr_addr_q;
  assign mb.wr_beat = wr_start ? '0 : wr_beat_q;

  // ----------------------------------------------------------------
  // read request pipeline
  // ----------------------------------------------------------------
  logic [1:0]                  rd_gap_q;
  logic                        rd_take;
  logic [qsp_pkg::PIPE_D-1:0]  rd_pipe_q;
  logic [qsp_pkg::MEM_AW-1:0]  rd_apipe_q [qsp_pkg::PIPE_D];
  logic [2:0]                  lat_idx;
  logic                        rd_start;

  // reads are spaced by a whole burst, i.e. every other positive rise
  assign rd_take = k_rise & ~rps_n_s & (rd_gap_q == 2'h0);  // R8 R11

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_gap_q <= 2'h0;
    end else if (rd_take) begin
      rd_gap_q <= qsp_pkg::RD_GAP;
    end else if (beat_edge && rd_gap_q != 2'h0) begin
      rd_gap_q <= rd_gap_q - 2'h1;
    end
  end

  // the pipeline advances one stage per clock rise of either polarity
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_pipe_q <= '0;
      for (int i = 0; i < qsp_pkg::PIPE_D; i++) begin
        rd_apipe_q[i] <= '0;
      end
    end else if (beat_edge) begin
      rd_pipe_q     <= {rd_pipe_q[qsp_pkg::PIPE_D-2:0], rd_take};
      rd_apipe_q[0] <= addr_s[qsp_pkg::MEM_AW-1:0];  // R5 R6
      for (int i = 1; i < qsp_pkg::PIPE_D; i++) begin
        rd_apipe_q[i] <= rd_apipe_q[i-1];
      end
    end
  end

  // mode pin is a level; changing it with reads in flight is not supported
  assign lat_idx  = pll_dis_n_s ? qsp_pkg::LAT_PLL_IDX : qsp_pkg::LAT_LEG_IDX;  // R16 R17
  assign rd_start = beat_edge & rd_pipe_q[lat_idx];

  // ----------------------------------------------------------------
  // read burst and output drivers
  // ----------------------------------------------------------------
  logic                        rd_act_q;
  logic [qsp_pkg::BEAT_W-1:0]  rd_beat_q;
  logic [qsp_pkg::MEM_AW-1:0]  rd_addr_q;
  logic [qsp_pkg::DATA_W-1:0]  q_q;
  logic                        oe_q;
  logic                        valid_q;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_act_q  <= 1'h0;
      rd_beat_q <= '0;
      rd_addr_q <= '0;
    end else if (rd_start) begin
      rd_act_q  <= 1'h1;
      rd_beat_q <= 2'h1;
      rd_addr_q <= rd_apipe_q[lat_idx];
    end else if (beat_edge && rd_act_q) begin
      rd_beat_q <= rd_beat_q + 2'h1;  // R9
      if (rd_beat_q == qsp_pkg::LAST_BEAT) begin
        rd_act_q <= 1'h0;
      end
    end
  end

  assign mb.rd_addr = rd_start ? rd_apipe_q[lat_idx] : rd_addr_q;
  assign mb.rd_beat = rd_start ? '0 : rd_beat_q;

  // each beat launches one word on the edge that carries it
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q_q <= '0;
    end else if (rd_start || (beat_edge && rd_act_q)) begin
      q_q <= mb.rd_data;  // R7 R12
    end
  end

  // flag moves only on clock edges, in step with the echo pair
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      valid_q <= 1'h0;
    end else if (beat_edge) begin
      valid_q <= rd_start | rd_act_q;  // R10
    end
  end

  // drivers turn off only at a positive rise once the burst is over
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      oe_q <= 1'h0;
    end else if (rd_start) begin
      oe_q <= 1'h1;  // R7
    end else if (k_rise && !rd_act_q) begin
      oe_q <= 1'h0;  // R8
    end
  end

  qsp_burst_mem u_mem (
    .clk_i (CLK_I),
    .bus   (mb.mem)
  );

  // ----------------------------------------------------------------
  // termination range, caught once after each reset release
  // ----------------------------------------------------------------
  logic [1:0] init_cnt_q;
  logic       term_done_q;
  logic       term_hi_q;

  // wait for the synchroniser to fill before trusting the pin
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      init_cnt_q  <= 2'h0;
      term_done_q <= 1'h0;
      term_hi_q   <= qsp_pkg::TERM_RST;
    end else if (!term_done_q) begin
      if (init_cnt_q == qsp_pkg::INIT_SETTLE) begin
        term_hi_q   <= odt_s;  // R14
        term_done_q <= 1'h1;
      end else begin
        init_cnt_q <= init_cnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign Q_O                 = q_q;
  assign Q_OE_O              = oe_q;
  assign OUTPUT_VALID_FLAG_O = valid_q;
  assign ECHO_TIMING_OUT_O   = cq_q;
  assign ECHO_TIMING_OUT_N_O = cqn_q;
  assign TERM_RANGE_HIGH_O   = term_hi_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_wr_deselect_idle : assert property ( // R1
    @(posedge CLK_I) disable iff (!RST_N_I)
    (k_rise && !wr_act_q && wps_n_s) |=> !wr_act_q)
    else $error("write started while port deselected");
  a_lane_off_kept : assert property ( // R2
    @(posedge CLK_I) disable iff (!RST_N_I)
    (wr_en && bws_n_s[0]) |-> !wr_lane[0] && (wr_lane[1] == !bws_n_s[1]))
    else $error("byte lane written against its select");
  a_wr_sample_active : assert property ( // R15
    @(posedge CLK_I) disable iff (!RST_N_I)
    wr_en |-> beat_edge && (wr_act_q || (k_rise && !wps_n_s)))
    else $error("write data taken outside an active write");
  a_wr_four_beats : assert property ( // R18
    @(posedge CLK_I) disable iff (!RST_N_I)
    $fell(wr_act_q) |-> $past(wr_beat_q) == qsp_pkg::LAST_BEAT && $past(beat_edge))
    else $error("write burst did not take four words");
  a_rd_four_beats : assert property ( // R9
    @(posedge CLK_I) disable iff (!RST_N_I)
    $fell(rd_act_q) |-> $past(rd_beat_q) == qsp_pkg::LAST_BEAT)
    else $error("read burst did not give four words");
  a_pll_latency : assert property ( // R16
    @(posedge CLK_I) disable iff (!RST_N_I)
    (beat_edge && rd_pipe_q[4] && pll_dis_n_s) |-> kn_rise ##1 (valid_q && oe_q))
    else $error("pll read word not out after five half cycles");
  a_legacy_latency : assert property ( // R17
    @(posedge CLK_I) disable iff (!RST_N_I)
    (beat_edge && rd_pipe_q[1] && !pll_dis_n_s) |-> k_rise ##1 (valid_q && oe_q))
    else $error("legacy read word not out after one cycle");
  a_take_on_k : assert property ( // R11
    @(posedge CLK_I) disable iff (!RST_N_I)
    (rd_take || wr_start) |-> k_rise && !kn_rise)
    else $error("access started off a positive rise");
  a_q_on_edge : assert property ( // R7
    @(posedge CLK_I) disable iff (!RST_N_I)
    $changed(q_q) |-> $past(beat_edge) && $past(rd_start || rd_act_q))
    else $error("read word moved without a clock rise");
  a_valid_echo : assert property ( // R10
    @(posedge CLK_I) disable iff (!RST_N_I)
    $changed(valid_q) |-> $changed(cq_q) || $changed(cqn_q))
    else $error("valid flag not aligned to echo edge");
  a_float_after : assert property ( // R8
    @(posedge CLK_I) disable iff (!RST_N_I)
    (k_rise && !rd_act_q && !rd_start) |=> !oe_q ##1 !oe_q || valid_q)
    else $error("outputs still driven after burst end");
  a_echo_runs : assert property ( // R13
    @(posedge CLK_I) disable iff (!RST_N_I)
    beat_edge |=> ($rose(cq_q) || $rose(cqn_q)))
    else $error("echo clock missed an input rise");
  a_term_hold : assert property ( // R14
    @(posedge CLK_I) disable iff (!RST_N_I)
    term_done_q |=> term_done_q && $stable(term_hi_q))
    else $error("termination range changed after capture");

endmodule : qsp_sram_port

`default_nettype wire

// ==== design/qsp_pkg.sv ====
// shared constants for the burst sram port
package qsp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W  = 21;  // narrow configuration
  localparam int unsigned DATA_W  = 18;
  localparam int unsigned LANE_W  = 9;
  localparam int unsigned LANES   = 2;
  localparam int unsigned BEAT_W  = 2;
  localparam int unsigned MEM_AW  = 4;   // burst locations held in flops
  localparam int unsigned PIPE_D  = 5;   // deepest read latency in edges
  localparam int unsigned SYNC_W  = 6 + LANES + ADDR_W + DATA_W;

  // ----------------------------------------------------------------
  // burst and latency counts, in half cycles of the input clock
  // ----------------------------------------------------------------
  localparam int unsigned     BURST_LEN      = 4;
  localparam logic [1:0]      LAST_BEAT      = 2'(BURST_LEN - 1);
  localparam logic [1:0]      RD_GAP         = 2'(BURST_LEN - 1);
  localparam int unsigned     LAT_PLL_HALF   = 5;
  localparam int unsigned     LAT_LEG_HALF   = 2;
  localparam logic [2:0]      LAT_PLL_IDX    = 3'(LAT_PLL_HALF - 1);
  localparam logic [2:0]      LAT_LEG_IDX    = 3'(LAT_LEG_HALF - 1);

  // ----------------------------------------------------------------
  // power-up and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]      INIT_SETTLE    = 2'h3;
  localparam logic            TERM_RST       = 1'h1;

endpackage : qsp_pkg

// ==== design/qsp_mem_if.sv ====
// bundle between the port logic and the burst storage
`timescale 1ns/10ps
`default_nettype none

interface qsp_mem_if;
  logic                          wr_en;
  logic [qsp_pkg::MEM_AW-1:0]    wr_addr;
  logic [qsp_pkg::BEAT_W-1:0]    wr_beat;
  logic [qsp_pkg::DATA_W-1:0]    wr_data;
  logic [qsp_pkg::LANES-1:0]     wr_lane;
  logic [qsp_pkg::MEM_AW-1:0]    rd_addr;
  logic [qsp_pkg::BEAT_W-1:0]    rd_beat;
  logic [qsp_pkg::DATA_W-1:0]    rd_data;

  modport ctl (output wr_en, wr_addr, wr_beat, wr_data, wr_lane, rd_addr, rd_beat, input rd_data);
  modport mem (input wr_en, wr_addr, wr_beat, wr_data, wr_lane, rd_addr, rd_beat, output rd_data);
endinterface : qsp_mem_if

`default_nettype wire

// ==== design/qsp_sync.sv ====
// two-flop synchroniser for the pin inputs
`timescale 1ns/10ps
`default_nettype none

module qsp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // ----------------------------------------------------------------
  // one pair per bit; the first flop feeds only the second
  // ----------------------------------------------------------------
  for (genvar b = 0; b < W; b++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_q <= 1'h0;
        sync_q <= 1'h0;
      end else begin
        meta_q <= d_i[b];
        sync_q <= meta_q;
      end
    end
    assign q_o[b] = sync_q;
  end

endmodule : qsp_sync

`default_nettype wire

// ==== design/qsp_burst_mem.sv ====
// flop storage of four-word burst locations with byte lanes
`timescale 1ns/10ps
`default_nettype none

module qsp_burst_mem (
  input  wire logic clk_i,
  qsp_mem_if.mem    bus
);

  localparam int unsigned DEPTH = (1 << qsp_pkg::MEM_AW) * qsp_pkg::BURST_LEN;

  logic [qsp_pkg::MEM_AW+1:0] wr_idx;
  logic [qsp_pkg::MEM_AW+1:0] rd_idx;

  // word index is location then beat, so a burst walks consecutive words
  assign wr_idx = {bus.wr_addr, bus.wr_beat};
  assign rd_idx = {bus.rd_addr, bus.rd_beat};

  // ----------------------------------------------------------------
  // one array per lane; a lane left unselected keeps its old byte
  // ----------------------------------------------------------------
  for (genvar l = 0; l < qsp_pkg::LANES; l++) begin : g_lane
    logic [qsp_pkg::LANE_W-1:0] lane_q [DEPTH];
    // contents are undefined after power-up, like the array they model
    always_ff @(posedge clk_i) begin
      if (bus.wr_en && bus.wr_lane[l]) begin
        lane_q[wr_idx] <= bus.wr_data[l*qsp_pkg::LANE_W +: qsp_pkg::LANE_W];
      end
    end
    assign bus.rd_data[l*qsp_pkg::LANE_W +: qsp_pkg::LANE_W] = lane_q[rd_idx];
  end

endmodule : qsp_burst_mem

`default_nettype wire

// ==== sim/qsp_ctl_model.sv ====
// controller-side model: input clocks, port selects, address and write data
`timescale 1ns/10ps
`default_nettype none

module qsp_ctl_model (
  output logic        k_o,
  output logic        k_n_o,
  output logic        wsel_n_o,
  output logic        rsel_n_o,
  output logic [1:0]  lane_n_o,
  output logic [20:0] addr_o,
  output logic [17:0] d_o
);
  // ----------------------------------------------------------------
  // input clock pair
  // ----------------------------------------------------------------
  // the pair runs free at 400 ns; selects idle high
  initial begin
    k_o      = 1'h0;
    wsel_n_o = 1'h1;
    rsel_n_o = 1'h1;
    lane_n_o = 2'h3;
    addr_o   = 21'h0;
    d_o      = 18'h0;
  end

  always #200 k_o = ~k_o;
  assign k_n_o = ~k_o;

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // pins move midway between rises so the capture edge sees them settled;
  // released lines flip so a stale value can never pass for a fresh one
  task automatic wr(input logic [20:0] a, input logic [17:0] w [4], input logic [7:0] ln, input logic en);
    @(posedge k_o);
    #300;
    wsel_n_o = ~en;
    addr_o   = a;
    for (int i = 0; i < 4; i++) begin
      d_o      = w[i];
      lane_n_o = ln[2*i+:2];
      #200;
      // select and address are released once, after word 0; a read may own the address at the next rise
      if (i == 0) begin
        wsel_n_o = 1'h1;
        addr_o   = ~a;
      end
    end
    d_o      = ~d_o;
    lane_n_o = ~lane_n_o;
  endtask : wr

  // read select low for exactly one positive rise; returns 100 ns after it
  task automatic rd(input logic [20:0] a);
    @(posedge k_o);
    #300;
    rsel_n_o = 1'h0;
    addr_o   = a;
    #200;
    rsel_n_o = 1'h1;
    addr_o   = ~a;
  endtask : rd
endmodule : qsp_ctl_model

`default_nettype wire

// ==== sim/test_qsp_sram_port.sv ====
// testbench of the burst sram port against the controller model
`timescale 1ns/10ps
`default_nettype none

module test_qsp_sram_port;
  // ----------------------------------------------------------------
  // pins and bookkeeping
  // ----------------------------------------------------------------
  logic        clk   = 1'h0;
  logic        rst_n = 1'h0;
  logic        term  = 1'h1;
  logic        pll_n = 1'h1;
  logic        k, k_n, wsel_n, rsel_n, q_oe, vld, echo, echo_n, term_o;
  logic [1:0]  lane_n;
  logic [20:0] addr;
  logic [17:0] d, q;
  logic [17:0] exp_m [16][4];
  int          lat        = 5;
  int          mismatches = 0;
  int          tests_run  = 0;

  always #25 clk = ~clk;

  qsp_ctl_model ctl (.k_o(k), .k_n_o(k_n), .wsel_n_o(wsel_n), .rsel_n_o(rsel_n), .lane_n_o(lane_n),
                     .addr_o(addr), .d_o(d));

  qsp_sram_port DUT (
    .CLK_I                      (clk),
    .RST_N_I                    (rst_n),
    .K_I                        (k),
    .K_N_I                      (k_n),
    .WRITE_PORT_SELECT_N_I      (wsel_n),
    .READ_PORT_SELECT_N_I       (rsel_n),
    .BYTE_LANE_WRITE_SELECT_N_I (lane_n),
    .ADDR_I                     (addr),
    .D_I                        (d),
    .TERMINATION_RANGE_SELECT_I (term),
    .PLL_DISABLE_N_I            (pll_n),
    .Q_O                        (q),
    .Q_OE_O                     (q_oe),
    .OUTPUT_VALID_FLAG_O        (vld),
    .ECHO_TIMING_OUT_O          (echo),
    .ECHO_TIMING_OUT_N_O        (echo_n),
    .TERM_RANGE_HIGH_O          (term_o)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [17:0] g, input logic [17:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk

  task automatic test_done();
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // only change the mode with no read in flight
  task automatic mode(input logic pn);
    @(negedge clk);
    pll_n = pn;
    lat   = pn ? 5 : 2;
  endtask : mode

  // write a burst and fold the selected lanes into the expected image
  task automatic wr(input logic [20:0] a, input logic [7:0] b, input logic [7:0] ln, input logic en);
    logic [17:0] w [4];
    for (int i = 0; i < 4; i++) begin
      w[i] = {b, 2'(i), b};
      for (int j = 0; j < 2; j++) begin
        if (en && !ln[2*i+j]) begin
          exp_m[a[3:0]][i][9*j+:9] = w[i][9*j+:9];
        end
      end
    end
    ctl.wr(a, w, ln, en);
  endtask : wr

  // judge flag before, each word at its edge, and the release after
  task automatic rd(input logic [20:0] a, input logic pre, input logic post);
    logic [17:0] e [4];
    e = exp_m[a[3:0]];
    ctl.rd(a);
    #(lat * 200 - 110);
    if (pre) begin
      chk(18'(vld), 18'h0, "valid early");
    end
    #200;
    for (int i = 0; i < 4; i++) begin
      chk(q, e[i], "read word");
      chk(18'({vld, q_oe}), 18'h3, "valid or enable");
      #200;
    end
    if (post) begin
      #200;
      chk(18'({vld, q_oe}), 18'h0, "release");
    end
  endtask : rd

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_echo();
    for (int i = 0; i < 2; i++) begin
      @(posedge k);
      #190;
      chk(18'({echo, echo_n}), 18'h2, "echo high");
      #200;
      chk(18'({echo, echo_n}), 18'h1, "echo low");
    end
  endtask : t_echo

  task automatic t_mode(input logic pn);
    mode(pn);
    wr(21'h3, pn ? 8'hA5 : 8'h3C, 8'h00, 1'h1);
    rd(21'h3, 1'h1, 1'h1);
  endtask : t_mode

  // word 0 both lanes, word 1 upper only, word 2 lower only, word 3 none
  task automatic t_lanes();
    wr(21'h1_0007, 8'h11, 8'h00, 1'h1);
    wr(21'h0_0007, 8'h5A, 8'hE4, 1'h1);
    rd(21'h1A_5A37, 1'h1, 1'h1);
  endtask : t_lanes

  task automatic t_desel();
    wr(21'h7, 8'hC3, 8'h00, 1'h0);
    rd(21'h7, 1'h1, 1'h1);
  endtask : t_desel

  // second read two rises later keeps the flag high without a gap
  task automatic t_b2b();
    fork
      rd(21'h3, 1'h1, 1'h0);
      begin
        repeat (2) @(posedge k);
        rd(21'h7, 1'h0, 1'h1);
      end
    join
  endtask : t_b2b

  // a request one rise into a burst is dropped; the burst ends alone
  task automatic t_refused();
    fork
      rd(21'h3, 1'h1, 1'h1);
      begin
        @(posedge k);
        ctl.rd(21'h7);
      end
    join
  endtask : t_refused

  // write and read overlap, their addresses on alternate positive rises
  task automatic t_overlap();
    fork
      wr(21'h5, 8'h96, 8'h00, 1'h1);
      begin
        @(posedge k);
        rd(21'h3, 1'h1, 1'h1);
      end
    join
    rd(21'h5, 1'h1, 1'h1);
  endtask : t_overlap

  task automatic t_reset(input logic tv);
    @(negedge clk);
    term  = tv;
    rst_n = 1'h0;
    repeat (8) @(negedge clk);
    chk(18'({term_o, vld, q_oe}), 18'h4, "reset values");
    rst_n = 1'h1;
    repeat (8) @(negedge clk);
    chk(18'(term_o), 18'(tv), "range");
  endtask : t_reset

  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'h1;
    repeat (2) @(posedge k);
    t_echo();
    t_mode(1'h1);
    t_mode(1'h0);
    t_lanes();
    t_desel();
    mode(1'h1);
    t_b2b();
    t_refused();
    t_overlap();
    t_reset(1'h0);
    t_reset(1'h1);
    test_done();
  end

  // the sequence needs well under 60 us; a hang is cut off at 300 us
  initial begin
    #300000;
    mismatches++;
    test_done();
  end
endmodule : test_qsp_sram_port

`default_nettype wire
